// >>> rtl/sac_pkg.sv
package sac_pkg;
  localparam int unsigned ATTN_WIDTH       = 6;
  localparam int unsigned TOP_BIT          = 5;
  localparam int unsigned BOTTOM_BIT       = 0;
  localparam int unsigned SYNC_STAGES      = 2;
  // Step weight in tenths of a dB for the bottom bit; higher bits double it
  localparam int unsigned STEP_TENTHS_DB   = 5;
  localparam int unsigned MAX_TENTHS_DB    = 315;
  localparam logic [5:0]  ATTN_REFERENCE   = 6'h3F;
  localparam logic [5:0]  ATTN_MAXIMUM     = 6'h00;
  // Power-up word of the system-side copy; no value is documented
  localparam logic [5:0]  ATTN_RESET_WORD  = 6'h3F;
  localparam int unsigned LE_SETUP_NS      = 10;
  localparam int unsigned LE_SPACING_NS    = 630;
  localparam int unsigned SYS_CLK_MHZ      = 100;
  localparam int unsigned LE_SPACING_CYC   = (LE_SPACING_NS * SYS_CLK_MHZ) / 1000;
endpackage : sac_pkg

// >>> rtl/sac_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sac_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sac_sync_state_t;

  sac_sync_state_t state;
  sac_sync_state_t next_state;

  if (WIDTH < 1) begin : g_bad_width
    $error("sac_sync: WIDTH must be at least 1");
  end : g_bad_width

  always_comb begin
    next_state      = state;
    next_state.meta = i_async;
    next_state.sync = state.meta;
    if (i_rst) begin
      next_state = '0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    state <= next_state;
  end

  assign o_sync = state.sync;
endmodule : sac_sync
`default_nettype wire

// >>> rtl/sac_attn_ctrl.sv
// Functional notes
// - A 6-bit word is shifted in top bit first, so the first bit lands in the top position.
// - Bits are active low with weights 0.5 to 16 dB bottom to top, and all ones is minimum loss.
// - A latched all-zero word selects the maximum attenuation of 31.5 dB.
// - Every one of the 64 words is a valid setting, summing the weights of its cleared bits.
// - Serial clock edges are ignored while the load strobe is high.
// - Each data bit is captured on the rising edge of the serial clock.
// - With the strobe high the output follows the shift register; when low it holds the word.
// - Shifting continues while the output latch is holding and stops while it is passing.
`timescale 1ns/10ps
`default_nettype none
module sac_attn_ctrl
  import sac_pkg::*;
#(
  parameter int unsigned WIDTH = sac_pkg::ATTN_WIDTH
) (
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_serial_clk,
  input  wire logic                         i_serial_attn_input,
  input  wire logic                         i_load_strobe,
  output logic      [sac_pkg::ATTN_WIDTH-1:0] o_step_attenuator,
  output logic      [8:0]                   o_attn_tenths_db,
  output logic                              o_load_done
);
  import sac_pkg::*;

  // Elaboration checks: the shift path and the word output are sized from the
  // package, the loss adder and loss output are a fixed 9 bits, so refuse any mismatch here
  // rather than let a narrower field silently drop the top weight.
  if (WIDTH != ATTN_WIDTH) begin : g_bad_width
    $error("sac_attn_ctrl: WIDTH must equal ATTN_WIDTH");
  end : g_bad_width

  if (ATTN_WIDTH < 2) begin : g_bad_attn_width
    $error("sac_attn_ctrl: ATTN_WIDTH must be at least 2");
  end : g_bad_attn_width

  if (TOP_BIT != ATTN_WIDTH - 1) begin : g_bad_top_bit
    $error("sac_attn_ctrl: TOP_BIT must be the last bit of the word");
  end : g_bad_top_bit

  if (BOTTOM_BIT != 0) begin : g_bad_bottom_bit
    $error("sac_attn_ctrl: BOTTOM_BIT must be bit zero");
  end : g_bad_bottom_bit

  if (SYNC_STAGES != 2) begin : g_bad_sync
    $error("sac_attn_ctrl: only a two-stage crossing is built");
  end : g_bad_sync

  if ($bits(ATTN_RESET_WORD) != ATTN_WIDTH) begin : g_bad_reset_word
    $error("sac_attn_ctrl: reset word width differs from ATTN_WIDTH");
  end : g_bad_reset_word

  if (ATTN_REFERENCE != '1 || ATTN_MAXIMUM != '0) begin : g_bad_levels
    $error("sac_attn_ctrl: reference must be all ones, maximum all zeros");
  end : g_bad_levels

  // The loss output must hold the all-zero word's sum of weights
  if (MAX_TENTHS_DB != STEP_TENTHS_DB * ((1 << ATTN_WIDTH) - 1)) begin : g_bad_max
    $error("sac_attn_ctrl: MAX_TENTHS_DB disagrees with the step weight");
  end : g_bad_max

  if (MAX_TENTHS_DB > 511) begin : g_bad_loss_width
    $error("sac_attn_ctrl: loss output too narrow for MAX_TENTHS_DB");
  end : g_bad_loss_width

  // Link domain: shift register on the serial clock.
  // This clock belongs to the controller and only runs during a frame,
  // so nothing here may depend on a free-running edge; the word simply
  // sits in the shift register until the strobe exposes it.
  // More than six bits in a frame keep the last six.
  typedef struct packed {
    logic [ATTN_WIDTH-1:0] shift;
  } sac_link_state_t;

  sac_link_state_t link;
  sac_link_state_t next_link;

  // Strobe is sampled on the link clock here only as an edge qualifier;
  // the shift register holds its word while it is high.
  always_comb begin
    next_link = link;
    if (!i_load_strobe) begin
      // Shift toward the top: first bit in ends in the top position
      next_link.shift = {link.shift[ATTN_WIDTH-2:0], i_serial_attn_input};
    end
  end

  // No reset in the link domain: the serial clock only runs during frames
  always_ff @(posedge i_serial_clk) begin
    link <= next_link;
  end

  // System domain: the shift word and strobe cross by two-stage sync.
  // The word is only copied while the synchronised strobe is high, and the
  // controller may not clock while the strobe is high, so the word is
  // stable through the crossing.
  logic [ATTN_WIDTH-1:0] shift_sync;
  logic                  strobe_sync;

  sac_sync #(
    .WIDTH (ATTN_WIDTH)
  ) u_word_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   (link.shift),
    .o_sync    (shift_sync)
  );

  sac_sync #(
    .WIDTH (1)
  ) u_strobe_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   (i_load_strobe),
    .o_sync    (strobe_sync)
  );

  typedef struct packed {
    logic [ATTN_WIDTH-1:0] latch;
    logic [8:0]            tenths;
    logic                  strobe_d;
    logic                  done;
  } sac_sys_state_t;

  sac_sys_state_t sys;
  sac_sys_state_t next_sys;

  // Loss in tenths of a dB, built per bit: each cleared bit adds its own
  // binary weight, the bottom bit the step and every higher bit double
  // the one below.  A ripple of small adders is plenty at this width.
  logic [8:0] bit_loss [ATTN_WIDTH];
  logic [8:0] loss_acc [ATTN_WIDTH+1];
  logic [8:0] word_loss;

  assign loss_acc[0] = 9'h000;

  for (genvar b = 0; b < ATTN_WIDTH; b++) begin : g_weight
    localparam logic [8:0] WEIGHT = 9'(STEP_TENTHS_DB << b);
    assign bit_loss[b]   = shift_sync[b] ? 9'h000 : WEIGHT;
    assign loss_acc[b+1] = 9'(loss_acc[b] + bit_loss[b]);
  end : g_weight

  // All ones sums to nothing (reference), all zeros to the full range
  assign word_loss = loss_acc[ATTN_WIDTH];

  always_comb begin
    next_sys          = sys;
    next_sys.strobe_d = strobe_sync;
    next_sys.done     = 1'b0;

    // Transparent phase.  The word bits cross one by one, which is only
    // safe because the controller stops clocking before the strobe rises.
    // Copying from the second cycle of a synchronised high strobe gives
    // every bit one more full cycle to settle, at one cycle of latency;
    // the shortest legal strobe still leaves one copy cycle.
    if (strobe_sync && sys.strobe_d) begin
      next_sys.latch  = shift_sync;
      next_sys.tenths = word_loss;
    end

    // Hold phase: the falling strobe freezes the word; flag it once
    // The link side goes on shifting meanwhile, unseen here
    if (sys.strobe_d && !strobe_sync) begin
      next_sys.done = 1'b1;
    end

    // Reset parks the attenuator at minimum loss.  The shift register is
    // not reset, so the first load must follow a full word.
    if (i_rst) begin
      next_sys.latch    = ATTN_RESET_WORD;
      next_sys.tenths   = 9'h000;
      next_sys.strobe_d = 1'b0;
      next_sys.done     = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    sys <= next_sys;
  end

  // Every output comes straight from the system-domain register
  assign o_step_attenuator = sys.latch;
  assign o_attn_tenths_db  = sys.tenths;
  assign o_load_done       = sys.done;
endmodule : sac_attn_ctrl
`default_nettype wire

// >>> dv/sac_chk_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module sac_chk
  import sac_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  input wire logic       i_serial_clk,
  input wire logic       i_serial_attn_input,
  input wire logic       i_load_strobe,
  input wire logic [5:0] o_step_attenuator,
  input wire logic [8:0] o_attn_tenths_db,
  input wire logic       o_load_done
);
  logic [5:0] sh;
  always_ff @(posedge i_serial_clk) if (!i_load_strobe) sh <= {sh[4:0], i_serial_attn_input};
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_fall; $fell(i_load_strobe); endsequence
  property p_loss; o_attn_tenths_db == 9'(5 * (6'h3F ^ o_step_attenuator)); endproperty
  a_loss: assert property (p_loss) else $error("loss off");
  property p_follow; i_load_strobe [*5] |-> o_step_attenuator == sh; endproperty
  a_follow: assert property (p_follow) else $error("no follow");
  property p_hold; !i_load_strobe [*5] |=> $stable(o_step_attenuator); endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  property p_done; s_fall |-> ##[2:4] o_load_done; endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_pulse; o_load_done |=> !o_load_done; endproperty
  a_pulse: assert property (p_pulse) else $error("long done");
  property p_reset;
    @(posedge i_sys_clk) disable iff (1'b0)
      i_rst |=> (o_step_attenuator == ATTN_RESET_WORD) && (o_attn_tenths_db == 9'h000)
        && !o_load_done;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state off");
endmodule : sac_chk
`default_nettype wire

// >>> dv/sac_host.sv
`timescale 1ns/10ps
`default_nettype none
module sac_host (
  output logic o_sclk,
  output logic o_sdata,
  output logic o_le
);
  initial {o_sclk, o_sdata, o_le} = 3'h0;
  // Link clock toggles inside a frame and, with junk set, once while the strobe is high; data idles at the inverse
  task automatic send(input logic [5:0] w, input bit junk);
    for (int i = 5; i >= 0; i--) begin
      o_sdata = w[i];
      #7.5 o_sclk = 1'b1;
      #7.5 o_sclk = 1'b0;
    end
    o_sdata = ~w[0];
    #10 o_le = 1'b1;
    if (junk) begin
      #5 o_sclk = 1'b1;
      #7.5 o_sclk = 1'b0;
    end
    #50 o_le = 1'b0;
    #630;
  endtask : send
endmodule : sac_host
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sac_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        sclk, sdat, le, done;
  logic [5:0]  attn;
  logic [8:0]  db;
  logic [5:0]  q[$];
  logic [5:0]  tbl[8] = '{6'h3F, 6'h3E, 6'h3D, 6'h3B, 6'h37, 6'h2F, 6'h1F, 6'h00};
  logic [31:0] rnd = 32'h079771CD;
  int          n_fail, n_compared, cyc;
  sac_attn_ctrl sac_attn_ctrl_i (.i_sys_clk, .i_rst, .i_serial_clk(sclk),
    .i_serial_attn_input(sdat), .i_load_strobe(le), .o_step_attenuator(attn),
    .o_attn_tenths_db(db), .o_load_done(done));
  sac_host sac_host_i (.o_sclk(sclk), .o_sdata(sdat), .o_le(le));
  initial forever #5 i_sys_clk = ~i_sys_clk;
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_word(input string nm, input logic [5:0] e, input logic [5:0] g);
    chk(nm, 9'(e), 9'(g));
  endtask : chk_word
  task automatic chk_loss(input string nm, input logic [8:0] e, input logic [8:0] g);
    chk(nm, e, g);
  endtask : chk_loss
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xorshift
  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic load(input logic [5:0] w, input bit junk);
    q.push_back(w);
    sac_host_i.send(w, junk);
  endtask : load
  // Outputs are read on the falling edge, well away from their launch
  always @(negedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      n_fail++;
      summarize();
    end
    if (done === 1'b1) begin
      chk_word("word", q[0], attn);
      chk_loss("loss", 9'(STEP_TENTHS_DB * (ATTN_REFERENCE ^ q[0])), db);
      void'(q.pop_front());
    end
  end
  initial begin
    repeat (16) @(posedge i_sys_clk);
    #1 i_rst = 1'b0;
    chk_word("rst word", ATTN_RESET_WORD, attn);
    chk_loss("rst loss", 9'h000, db);
    $display("test reset done");
    foreach (tbl[i]) load(tbl[i], i[0]);
    $display("test table done");
    repeat (16) begin
      rnd = xorshift(rnd);
      load(rnd[5:0], rnd[6]);
    end
    repeat (10) @(posedge i_sys_clk);
    chk("pending", 9'h000, 9'(q.size()));
    $display("test random done");
    summarize();
  end
endmodule : tb_top
bind sac_attn_ctrl sac_chk sac_chk_i (.i_sys_clk, .i_rst, .i_serial_clk, .i_serial_attn_input,
  .i_load_strobe, .o_step_attenuator, .o_attn_tenths_db, .o_load_done);
`default_nettype wire
